// *** irq_enable_pkg.sv ***
// Package for the interrupt enable and request gating block
package irq_enable_pkg;
   localparam logic [7:0] ADDR_BANK_A = 8'hA8;
   localparam logic [7:0] ADDR_BANK_B = 8'hA9;
   localparam logic [7:0] ADDR_BANK_C = 8'hAA;
   localparam logic [7:0] ADDR_BANK_D = 8'hAB;
   localparam logic [7:0] ADDR_SRC_A  = 8'hC0;
   localparam logic [7:0] ADDR_SRC_B  = 8'hC8;
   localparam logic [7:0] ADDR_TRIG   = 8'hC9;
   localparam logic [7:0] ADDR_PRIO0  = 8'hB8;
   localparam logic [7:0] ADDR_PRIO1  = 8'hB9;
   localparam logic [7:0] BANK_RESET  = 8'h00;
   localparam logic [7:0] MASK_BANK_A = 8'hBF;
   localparam logic [7:0] MASK_BANK_B = 8'h3E;
   localparam logic [7:0] MASK_BANK_C = 8'h3C;
   localparam logic [7:0] MASK_BANK_D = 8'h30;
   localparam logic [7:0] MASK_PRIO   = 8'h3F;
   localparam logic [7:0] MASK_TRIG   = 8'h03;
   localparam int         GLOBAL_BIT  = 7;
   localparam int         NUM_SLOTS   = 24;
   localparam int         NUM_GROUPS  = 6;
   localparam logic [23:0] IMPL_SLOTS = 24'hC3CFBF;

   // Source register A bit layout
   localparam int SA_L24 = 7;
   localparam int SA_ADC = 6;
   localparam int SA_WT  = 5;
   localparam int SA_AVS = 4;
   localparam int SA_DVS = 3;
   localparam int SA_PW  = 2;
   localparam int SA_AHS = 1;
   localparam int SA_DHS = 0;
   // Source register B bit layout
   localparam int SB_CC  = 7;
   localparam int SB_ADW = 6;
   localparam int SB_X1  = 1;
   localparam int SB_X0  = 0;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

   typedef struct packed {
      logic timer0_overflow_flag;
      logic timer1_overflow_flag;
      logic timer0_high_byte;
      logic timer_mode3;
      logic pin_irq0;
      logic ext_pin_irq1;
      logic pin_irq0_edge;
      logic pin_irq1_edge;
      logic extra_pin_irq0;
      logic extra_pin_irq1;
      logic serial_port;
      logic adc_done;
      logic watchdog_timer;
      logic acq_vsync;
      logic disp_vsync;
      logic pulse_timer;
      logic chan_change;
      logic acq_hsync;
      logic disp_hsync;
      logic teletext_row;
      logic adc_wakeup;
   } irq_src_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_TAKE = 3'b010,
      ST_WAIT = 3'b100
   } take_state_t;
endpackage : irq_enable_pkg

// *** interrupt_enable_control.sv ***
// Interrupt enable banks, source flags, trigger handling and priority pick
`timescale 1ns/1ns
`default_nettype none

module interrupt_enable_control (
   input  wire logic                        clk_i,
   input  wire logic                        reset_i,
   input  wire logic                        clk_en_i,
   input  wire irq_enable_pkg::sfr_req_t    sfr_req_i,
   input  wire irq_enable_pkg::irq_src_t    src_i,
   input  wire logic                        global_irq_inhibit_i,
   input  wire logic                        reti_i,
   input  wire logic                        ack_i,
   output logic [7:0]                       sfr_rdata_o,
   output logic                             irq_req_o,
   output logic [4:0]                       irq_slot_o,
   output logic [1:0]                       irq_level_o
);
   import irq_enable_pkg::*;

   logic [7:0]  bank_a_ff, bank_b_ff, bank_c_ff, bank_d_ff;
   logic [7:0]  src_a_ff, src_b_ff, trig_ff, prio0_ff, prio1_ff;
   logic [20:0] prev_ff;
   logic [23:0] flags, enables, pending;
   logic        allow;
   logic [3:0]  active_ff;
   logic [4:0]  nxt_slot;
   logic [1:0]  nxt_level;
   logic        nxt_found;
   take_state_t state_ff;
   logic [7:0]  rdata;
   logic        pin0_hit, pin1_hit, x0_hit, x1_hit, t1_src;

   function automatic logic wr_at(input sfr_req_t r, input logic [7:0] a);
      return r.wr && (r.addr == a);
   endfunction : wr_at

   function automatic logic rise(input logic now, input logic prev);
      return now && !prev;
   endfunction : rise

   function automatic logic [1:0] group_level(input int g, input logic [7:0] p0, input logic [7:0] p1);
      return {p1[g], p0[g]};
   endfunction : group_level

   // Enable banks, reserved bits held at zero
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         bank_a_ff <= BANK_RESET;
         bank_b_ff <= BANK_RESET;
         bank_c_ff <= BANK_RESET;
         bank_d_ff <= BANK_RESET;
      end else if (clk_en_i) begin
         if (wr_at(sfr_req_i, ADDR_BANK_A)) bank_a_ff <= sfr_req_i.wdata & MASK_BANK_A;
         if (wr_at(sfr_req_i, ADDR_BANK_B)) bank_b_ff <= sfr_req_i.wdata & MASK_BANK_B;
         if (wr_at(sfr_req_i, ADDR_BANK_C)) bank_c_ff <= sfr_req_i.wdata & MASK_BANK_C;
         if (wr_at(sfr_req_i, ADDR_BANK_D)) bank_d_ff <= sfr_req_i.wdata & MASK_BANK_D;
      end
   end

   // Priority and trigger select registers
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         prio0_ff <= BANK_RESET;
         prio1_ff <= BANK_RESET;
         trig_ff  <= BANK_RESET;
      end else if (clk_en_i) begin
         if (wr_at(sfr_req_i, ADDR_PRIO0)) prio0_ff <= sfr_req_i.wdata & MASK_PRIO;
         if (wr_at(sfr_req_i, ADDR_PRIO1)) prio1_ff <= sfr_req_i.wdata & MASK_PRIO;
         if (wr_at(sfr_req_i, ADDR_TRIG))  trig_ff  <= sfr_req_i.wdata & MASK_TRIG;
      end
   end

   // Previous samples for edge detection
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         prev_ff <= '0;
      end else if (clk_en_i) begin
         prev_ff <= {src_i.pin_irq0, src_i.ext_pin_irq1, src_i.extra_pin_irq0, src_i.extra_pin_irq1,
                     src_i.adc_done, src_i.watchdog_timer, src_i.acq_vsync, src_i.disp_vsync,
                     src_i.pulse_timer, src_i.chan_change, src_i.acq_hsync, src_i.disp_hsync,
                     src_i.teletext_row, src_i.adc_wakeup, 7'h00};
      end
   end

   // Extra pins: trig bit 0 or 1 selects rising, else falling
   always_comb begin
      x0_hit = trig_ff[0] ? rise(src_i.extra_pin_irq0, prev_ff[18])
                          : rise(prev_ff[18], src_i.extra_pin_irq0);
      x1_hit = trig_ff[1] ? rise(src_i.extra_pin_irq1, prev_ff[17])
                          : rise(prev_ff[17], src_i.extra_pin_irq1);
      // Main pins: edge select comes from timer and irq control bits
      pin0_hit = src_i.pin_irq0_edge ? rise(src_i.pin_irq0, prev_ff[20]) : src_i.pin_irq0;
      pin1_hit = src_i.pin_irq1_edge ? rise(src_i.ext_pin_irq1, prev_ff[19]) : src_i.ext_pin_irq1;
      t1_src   = src_i.timer_mode3 ? src_i.timer0_high_byte : src_i.timer1_overflow_flag;
   end

   // Central source flags: set wins over software clear
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         src_a_ff <= BANK_RESET;
         src_b_ff <= BANK_RESET;
      end else if (clk_en_i) begin
         logic [7:0] set_a;
         logic [7:0] set_b;
         logic [7:0] keep_a;
         logic [7:0] keep_b;
         set_a = '0;
         set_b = '0;
         set_a[SA_L24] = rise(src_i.teletext_row,   prev_ff[8]);
         set_a[SA_ADC] = rise(src_i.adc_done,       prev_ff[16]);
         set_a[SA_WT]  = rise(src_i.watchdog_timer, prev_ff[15]);
         set_a[SA_AVS] = rise(src_i.acq_vsync,      prev_ff[14]);
         set_a[SA_DVS] = rise(src_i.disp_vsync,     prev_ff[13]);
         set_a[SA_PW]  = rise(src_i.pulse_timer,    prev_ff[12]);
         set_a[SA_AHS] = rise(src_i.acq_hsync,      prev_ff[10]);
         set_a[SA_DHS] = rise(src_i.disp_hsync,     prev_ff[9]);
         set_b[SB_CC]  = rise(src_i.chan_change,    prev_ff[11]);
         set_b[SB_ADW] = rise(src_i.adc_wakeup,     prev_ff[7]);
         set_b[SB_X1]  = x1_hit;
         set_b[SB_X0]  = x0_hit;
         keep_a = wr_at(sfr_req_i, ADDR_SRC_A) ? sfr_req_i.wdata : src_a_ff;
         keep_b = wr_at(sfr_req_i, ADDR_SRC_B) ? sfr_req_i.wdata : src_b_ff;
         src_a_ff <= keep_a | set_a;
         src_b_ff <= (keep_b | set_b) & 8'hC3;
      end
   end

   // Slot map: bank k bit g is slot 6*k+g; reserved slots stay zero
   always_comb begin
      flags = '0;
      flags[0]  = pin0_hit;
      flags[1]  = src_i.timer0_overflow_flag;
      flags[2]  = pin1_hit;
      flags[3]  = t1_src;
      flags[4]  = src_i.serial_port;
      flags[5]  = src_a_ff[SA_ADC];
      flags[7]  = src_b_ff[SB_X0];
      flags[8]  = src_a_ff[SA_WT];
      flags[9]  = src_b_ff[SB_X1];
      flags[10] = src_a_ff[SA_AVS];
      flags[11] = src_a_ff[SA_DVS];
      flags[14] = src_a_ff[SA_PW];
      flags[15] = src_b_ff[SB_CC];
      flags[16] = src_a_ff[SA_AHS];
      flags[17] = src_a_ff[SA_DHS];
      flags[22] = src_a_ff[SA_L24];
      flags[23] = src_b_ff[SB_ADW];
      enables = {bank_d_ff[5:0], bank_c_ff[5:0], bank_b_ff[5:0], bank_a_ff[5:0]};
      allow   = bank_a_ff[GLOBAL_BIT] && !global_irq_inhibit_i;
      pending = (allow ? (flags & enables) : '0) & IMPL_SLOTS;
   end

   // Highest level first, then scan order by group and bank
   always_comb begin
      nxt_found = 1'b0;
      nxt_slot  = '0;
      nxt_level = '0;
      for (int lv = 3; lv >= 0; lv--) begin
         for (int g = 0; g < NUM_GROUPS; g++) begin
            for (int k = 0; k < 4; k++) begin
               if (!nxt_found && pending[6*k+g] && (group_level(g, prio0_ff, prio1_ff) == 2'(lv))
                   && !(|(active_ff >> lv))) begin
                  nxt_found = 1'b1;
                  nxt_slot  = 5'(6*k+g);
                  nxt_level = 2'(lv);
               end
            end
         end
      end
   end

   // Request handshake and nesting record
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_ff    <= ST_IDLE;
         active_ff   <= '0;
         irq_req_o   <= 1'b0;
         irq_slot_o  <= '0;
         irq_level_o <= '0;
      end else if (clk_en_i) begin
         case (state_ff)
            ST_IDLE: begin
               if (nxt_found) begin
                  irq_req_o   <= 1'b1;
                  irq_slot_o  <= nxt_slot;
                  irq_level_o <= nxt_level;
                  state_ff    <= ST_TAKE;
               end
            end
            ST_TAKE: begin
               if (ack_i) begin
                  irq_req_o              <= 1'b0;
                  active_ff[irq_level_o] <= 1'b1;
                  state_ff               <= ST_WAIT;
               end else if (!allow) begin
                  irq_req_o <= 1'b0;
                  state_ff  <= ST_IDLE;
               end
            end
            ST_WAIT: state_ff <= ST_IDLE;
            default: state_ff <= ST_IDLE;
         endcase
         if (reti_i && state_ff != ST_TAKE) begin
            for (int lv = 3; lv >= 0; lv--) begin
               if (active_ff[lv] && !(|(active_ff >> (lv + 1)))) active_ff[lv] <= 1'b0;
            end
         end
      end
   end

   // Register read path
   always_comb begin
      case (sfr_req_i.addr)
         ADDR_BANK_A: rdata = bank_a_ff;
         ADDR_BANK_B: rdata = bank_b_ff;
         ADDR_BANK_C: rdata = bank_c_ff;
         ADDR_BANK_D: rdata = bank_d_ff;
         ADDR_SRC_A:  rdata = src_a_ff;
         ADDR_SRC_B:  rdata = src_b_ff;
         ADDR_TRIG:   rdata = trig_ff;
         ADDR_PRIO0:  rdata = prio0_ff;
         ADDR_PRIO1:  rdata = prio1_ff;
         default:     rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) sfr_rdata_o <= 8'h00;
      else if (clk_en_i && sfr_req_i.rd) sfr_rdata_o <= rdata;
   end

   chk_inhibit_blocks: assert property (@(posedge clk_i) disable iff (reset_i)
      clk_en_i && global_irq_inhibit_i && state_ff == ST_IDLE |=> !irq_req_o)
      else $error("request raised while inhibited");
   chk_global_off: assert property (@(posedge clk_i) disable iff (reset_i)
      clk_en_i && !bank_a_ff[7] && state_ff == ST_IDLE |=> !irq_req_o)
      else $error("request raised with global enable off");
   chk_reserved_zero: assert property (@(posedge clk_i) disable iff (reset_i)
      bank_b_ff[7:6] == 2'b00 && bank_c_ff[7:6] == 2'b00 && bank_d_ff[7:0] == (bank_d_ff & 8'h30))
      else $error("reserved enable bits set");
   chk_slot_real: assert property (@(posedge clk_i) disable iff (reset_i)
      irq_req_o |-> IMPL_SLOTS[irq_slot_o])
      else $error("reserved slot requested");
   chk_flag_sets: assert property (@(posedge clk_i) disable iff (reset_i)
      clk_en_i && src_i.adc_done && !prev_ff[16] |=> src_a_ff[SA_ADC])
      else $error("converter flag not set on rise");
   chk_req_enabled: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(irq_req_o) |-> enables[irq_slot_o] || $past(enables[irq_slot_o]))
      else $error("request for disabled slot");
   chk_level_match: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(irq_req_o) |-> irq_level_o == $past(nxt_level))
      else $error("level mismatch");
   chk_bank_write: assert property (@(posedge clk_i) disable iff (reset_i)
      clk_en_i && wr_at(sfr_req_i, ADDR_BANK_A) |=> bank_a_ff == ($past(sfr_req_i.wdata) & MASK_BANK_A))
      else $error("bank a write lost");
endmodule : interrupt_enable_control

`default_nettype wire

// *** core_model.sv ***
// Behavioural core that takes offered requests and returns from service
`timescale 1ns/1ns
`default_nettype none
module core_model #(
   parameter int ACK_DELAY = 2
) (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic irq_req_i,
   input  wire logic ack_en_i,
   input  wire logic ret_cmd_i,
   output logic      ack_o,
   output logic      reti_o
);
   int wait_ff;

   // Takes a standing request after a delay, one-cycle pulse
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ack_o   <= 1'b0;
         wait_ff <= 0;
      end else if (irq_req_i && ack_en_i && !ack_o) begin
         ack_o   <= (wait_ff >= ACK_DELAY);
         wait_ff <= (wait_ff >= ACK_DELAY) ? 0 : wait_ff + 1;
      end else begin
         ack_o   <= 1'b0;
         wait_ff <= 0;
      end
   end

   // Return from service ends the highest active level, except while the block is in ST_TAKE
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         reti_o <= 1'b0;
      end else begin
         reti_o <= ret_cmd_i;
      end
   end
endmodule : core_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the interrupt enable and request gating block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import irq_enable_pkg::*;
   logic       clk_i = 1'b0;
   logic       reset_i = 1'b1;
   sfr_req_t   sfr_req = '0;
   irq_src_t   src = '0;
   logic       inhibit = 1'b0;
   logic       clk_en = 1'b1;
   logic       ack_en = 1'b0;
   logic       ret_cmd = 1'b0;
   logic       ack;
   logic       reti;
   logic [7:0] sfr_rdata;
   logic       irq_req;
   logic [4:0] irq_slot;
   logic [1:0] irq_level;
   logic [7:0] masks [4] = '{MASK_BANK_A, MASK_BANK_B, MASK_BANK_C, MASK_BANK_D};
   int         mismatches = 0;
   int         compares = 0;

   always #5 clk_i = ~clk_i;

   interrupt_enable_control i_dut (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(clk_en), .sfr_req_i(sfr_req),
      .src_i(src), .global_irq_inhibit_i(inhibit), .reti_i(reti), .ack_i(ack), .sfr_rdata_o(sfr_rdata),
      .irq_req_o(irq_req), .irq_slot_o(irq_slot), .irq_level_o(irq_level));

   core_model #(.ACK_DELAY(3)) i_core (.clk_i(clk_i), .reset_i(reset_i), .irq_req_i(irq_req),
      .ack_en_i(ack_en), .ret_cmd_i(ret_cmd), .ack_o(ack), .reti_o(reti));

   task automatic end_sim();
      $display("Comparisons %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim

   task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : check8

   task automatic check_bit(input string name, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
      end
   endtask : check_bit

   task automatic sfr_wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk_i);
      sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge clk_i);
      sfr_req <= '0;
   endtask : sfr_wr

   task automatic check_rd(input logic [7:0] addr, input logic [7:0] exp);
      @(posedge clk_i);
      sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
      @(posedge clk_i);
      sfr_req <= '0;
      #1;
      check8("sfr_rdata_o", exp, sfr_rdata);
   endtask : check_rd

   // Bounded wait for an offer, then its slot and level
   task automatic wait_req(input logic [4:0] slot, input logic [1:0] lvl);
      int n;
      n = 0;
      #1;
      while (irq_req !== 1'b1 && n < 20) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      check_bit("irq_req_o", 1'b1, irq_req);
      check8("irq_slot_o", {3'h0, slot}, {3'h0, irq_slot});
      check8("irq_level_o", {6'h00, lvl}, {6'h00, irq_level});
      if (irq_req !== 1'b1) begin
         end_sim();
      end
   endtask : wait_req

   // Return only once the core has taken the standing offer
   task automatic end_service();
      int n;
      n = 0;
      #1;
      while (irq_req === 1'b1 && n < 20) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      check_bit("irq_req_o", 1'b0, irq_req);
      if (irq_req !== 1'b0) begin
         end_sim();
      end
      @(posedge clk_i);
      ret_cmd <= 1'b1;
      @(posedge clk_i);
      ret_cmd <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : end_service

   initial begin
      src.extra_pin_irq1 <= 1'b1;
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         check_rd(ADDR_BANK_A + 8'(i), 8'h00);
      end
      for (int i = 0; i < 4; i++) begin
         sfr_wr(ADDR_BANK_A + 8'(i), 8'hFF);
         check_rd(ADDR_BANK_A + 8'(i), masks[i]);
         sfr_wr(ADDR_BANK_A + 8'(i), 8'h00);
      end
      // Clock enable low freezes the banks
      clk_en <= 1'b0;
      sfr_wr(ADDR_BANK_D, 8'hFF);
      clk_en <= 1'b1;
      check_rd(ADDR_BANK_D, 8'h00);
      sfr_wr(8'h50, 8'hFF);
      check_rd(8'h50, 8'h00);
      // Source enabled but global enable off
      sfr_wr(ADDR_BANK_A, 8'h02);
      src.timer0_overflow_flag <= 1'b1;
      repeat (4) @(posedge clk_i);
      #1;
      check_bit("irq_req_o", 1'b0, irq_req);
      sfr_wr(ADDR_BANK_A, 8'h82);
      wait_req(5'd1, 2'd0);
      @(posedge clk_i);
      inhibit <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      check_bit("irq_req_o", 1'b0, irq_req);
      @(posedge clk_i);
      inhibit <= 1'b0;
      wait_req(5'd1, 2'd0);
      @(posedge clk_i);
      ack_en <= 1'b1;
      repeat (8) @(posedge clk_i);
      #1;
      check_bit("irq_req_o", 1'b0, irq_req);
      // Higher group level preempts the running level 0 service
      sfr_wr(ADDR_PRIO0, 8'h20);
      sfr_wr(ADDR_PRIO1, 8'h20);
      sfr_wr(ADDR_BANK_A, 8'hA2);
      src.adc_done <= 1'b1;
      @(posedge clk_i);
      src.adc_done <= 1'b0;
      wait_req(5'd5, 2'd3);
      check_rd(ADDR_SRC_A, 8'h40);
      sfr_wr(ADDR_SRC_A, 8'h00);
      check_rd(ADDR_SRC_A, 8'h00);
      src.timer0_overflow_flag <= 1'b0;
      end_service();
      end_service();
      // Timer mode 3 moves the timer 1 request to the high byte
      src.timer_mode3 <= 1'b1;
      src.timer0_high_byte <= 1'b1;
      sfr_wr(ADDR_BANK_A, 8'h88);
      wait_req(5'd3, 2'd0);
      @(posedge clk_i);
      src.timer0_high_byte <= 1'b0;
      end_service();
      // Extra pin 0 on rising edge, extra pin 1 on falling edge
      sfr_wr(ADDR_TRIG, 8'h01);
      sfr_wr(ADDR_BANK_B, 8'h0A);
      sfr_wr(ADDR_BANK_A, 8'h80);
      src.extra_pin_irq0 <= 1'b1;
      wait_req(5'd7, 2'd0);
      sfr_wr(ADDR_SRC_B, 8'h00);
      end_service();
      src.extra_pin_irq1 <= 1'b0;
      wait_req(5'd9, 2'd0);
      // Every peripheral line but adc_done latches its central flag on a rise
      @(posedge clk_i);
      src.teletext_row   <= 1'b1;
      src.watchdog_timer <= 1'b1;
      src.acq_vsync      <= 1'b1;
      src.disp_vsync     <= 1'b1;
      src.pulse_timer    <= 1'b1;
      src.acq_hsync      <= 1'b1;
      src.disp_hsync     <= 1'b1;
      src.chan_change    <= 1'b1;
      src.adc_wakeup     <= 1'b1;
      check_rd(ADDR_SRC_A, 8'hBF);
      check_rd(ADDR_SRC_B, 8'hC2);
      end_sim();
   end
endmodule : testbench
`default_nettype wire
